// *** hw/lsti_cfg.svh ***
// Constants of the light sensor threshold interrupt block
`ifndef LSTI_CFG_SVH
`define LSTI_CFG_SVH

// ----------------------------------------------------------------------------
// Register map and fields
// ----------------------------------------------------------------------------
`define LSTI_ADDR_W          5
`define LSTI_OFS_IRQ_CTRL    5'h02
`define LSTI_IRQ_CTRL_RESET  8'h00
`define LSTI_IRQ_CTRL_MASK   8'h5F
`define LSTI_BIT_HALT        6
`define LSTI_BIT_MODE        4
`define LSTI_PERSIST_HI      3
`define LSTI_PERSIST_LO      0
`define LSTI_TRANS_CLEAR     2'h3
`define LSTI_PERSIST_ZERO    4'h0
`define LSTI_MANUAL_COUNT    8'h00

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define LSTI_INTERVAL_NS     2700000
`define LSTI_MCLK_NS         50

`endif

// *** hw/lsti_pkg.sv ***
// Types of the light sensor threshold interrupt block
package lsti_pkg;

  // Interrupt mode select
  typedef enum logic {
    LSTI_MODE_OFF   = 1'b0,
    LSTI_MODE_LEVEL = 1'b1
  } lsti_mode_t;

  // Integration timer states
  typedef enum logic [1:0] {
    LSTI_ST_IDLE = 2'b00,
    LSTI_ST_RUN  = 2'b01,
    LSTI_ST_HALT = 2'b10
  } lsti_state_t;

endpackage : lsti_pkg

// *** hw/lsti_persist.sv ***
// Persistence filter for channel 0 window results
`include "lsti_cfg.svh"

module lsti_persist #(
  parameter int CNT_W = 4
) (
  // Clock and reset
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  // Conversion result
  input  wire logic             i_conv_done,
  input  wire logic             i_outside,
  // Control
  input  wire logic [CNT_W-1:0] i_persist,
  input  wire logic             i_clear,
  // Qualified event
  output logic                  o_fire
);

  logic [CNT_W-1:0] run_cnt;
  logic [CNT_W-1:0] next_run_cnt;
  wire  [CNT_W-1:0] cnt_inc = run_cnt + CNT_W'(1);
  wire              sat     = (run_cnt == {CNT_W{1'b1}});

  assign o_fire = i_conv_done &&
                  ((i_persist == `LSTI_PERSIST_ZERO) || (i_outside && (cnt_inc >= i_persist || sat)));

  always_comb begin
    next_run_cnt = run_cnt;
    if (i_clear || (i_conv_done && !i_outside)) begin
      next_run_cnt = '0;
    end else if (i_conv_done && !sat) begin
      next_run_cnt = cnt_inc;
    end
  end

  // Consecutive out-of-window count
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      run_cnt <= '0;
    end else begin
      run_cnt <= next_run_cnt;
    end
  end

  chk_cnt_restart: assert property (@(posedge i_mclk) disable iff (i_reset)
    (i_clear || (i_conv_done && !i_outside)) |=> (run_cnt == '0))
    else $error("persistence count did not restart");

endmodule : lsti_persist

// *** hw/lsti_top.sv ***
// Threshold interrupt and integration timer of a two-channel light converter
`include "lsti_cfg.svh"

module lsti_top #(
  parameter int INTERVAL_CYC = (`LSTI_INTERVAL_NS + `LSTI_MCLK_NS - 1) / `LSTI_MCLK_NS,
  parameter int PERSIST_W    = 4
) (
  // Clock and reset
  input  wire logic                    i_mclk,
  input  wire logic                    i_reset,
  // Register write and read port
  input  wire logic                    i_reg_wr,
  input  wire logic [`LSTI_ADDR_W-1:0] i_reg_addr,
  input  wire logic [7:0]              i_reg_wdata,
  output logic      [7:0]              o_reg_rdata,
  // Command transaction strobe
  input  wire logic                    i_cmd_wr,
  input  wire logic [1:0]              i_cmd_transaction,
  // Settings from neighbouring registers
  input  wire logic                    i_adc_enable,
  input  wire logic [7:0]              i_integ_period_count,
  input  wire logic [15:0]             i_low_thresh,
  input  wire logic [15:0]             i_high_thresh,
  // Channel 0 conversion result
  input  wire logic                    i_conv_done,
  input  wire logic [15:0]             i_ch0_data,
  // Integration control
  output logic                         o_integ_run,
  output logic                         o_integ_end,
  output logic                         o_manual_mode,
  // Interrupt state and pin
  output logic                         o_irq_active,
  output logic                         o_irq_n_out,
  output logic                         o_irq_n_oe
);

  localparam int IVL_W = $clog2(INTERVAL_CYC + 1);

  // --------------------------------------------------------------------------
  // Interrupt control register
  // --------------------------------------------------------------------------
  logic [7:0] irq_ctrl;
  logic [7:0] rdata;

  wire        ctrl_hit   = i_reg_wr && (i_reg_addr == `LSTI_OFS_IRQ_CTRL);
  wire        halt_on_irq = irq_ctrl[`LSTI_BIT_HALT];
  wire        irq_mode_select = irq_ctrl[`LSTI_BIT_MODE];
  wire [PERSIST_W-1:0] persist = PERSIST_W'(irq_ctrl[`LSTI_PERSIST_HI:`LSTI_PERSIST_LO]);
  wire        mode_level = (lsti_pkg::lsti_mode_t'(irq_mode_select) == lsti_pkg::LSTI_MODE_LEVEL);
  wire [7:0]  next_rdata = (i_reg_addr == `LSTI_OFS_IRQ_CTRL) ? irq_ctrl : 8'h00;

  // Control register store; reserved bits kept at zero
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq_ctrl <= `LSTI_IRQ_CTRL_RESET;
    end else if (ctrl_hit) begin
      irq_ctrl <= i_reg_wdata & `LSTI_IRQ_CTRL_MASK;
    end
  end

  // Registered read data
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  assign o_reg_rdata = rdata;

  // --------------------------------------------------------------------------
  // Window compare and persistence
  // --------------------------------------------------------------------------
  logic irq;
  logic fire;

  wire outside   = (i_ch0_data <= i_low_thresh) || (i_ch0_data > i_high_thresh);
  wire irq_clear = i_cmd_wr && (i_cmd_transaction == `LSTI_TRANS_CLEAR);

  lsti_persist #(
    .CNT_W       (PERSIST_W)
  ) u_persist (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_conv_done (i_conv_done),
    .i_outside   (outside),
    .i_persist   (persist),
    .i_clear     (irq_clear),
    .o_fire      (fire)
  );

  wire irq_set  = fire && mode_level;
  // held until clear; set wins over clear
  wire next_irq = irq_set || (irq && !irq_clear);

  // Interrupt latch
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  assign o_irq_n_out  = 1'b0;
  assign o_irq_n_oe   = irq && mode_level;
  assign o_irq_active = irq;

  // --------------------------------------------------------------------------
  // Integration timer
  // --------------------------------------------------------------------------
  lsti_pkg::lsti_state_t state;
  lsti_pkg::lsti_state_t next_state;
  logic [IVL_W-1:0]      ivl_cnt;
  logic [7:0]            per_cnt;
  logic                  integ_end;

  wire       manual     = (i_integ_period_count == `LSTI_MANUAL_COUNT);
  wire [7:0] per_target = 8'(~i_integ_period_count + 8'h01);
  wire       ivl_last   = (ivl_cnt == IVL_W'(INTERVAL_CYC - 1));
  wire       per_last   = (per_cnt == 8'(per_target - 8'h01));
  wire       period_end = (state == lsti_pkg::LSTI_ST_RUN) && ivl_last && per_last;
  wire       halt_req   = halt_on_irq && irq;

  // Timer state selection
  always_comb begin
    next_state = state;
    case (state)
      lsti_pkg::LSTI_ST_IDLE: begin
        if (i_adc_enable && !manual && !halt_req) begin
          next_state = lsti_pkg::LSTI_ST_RUN;
        end
      end
      lsti_pkg::LSTI_ST_RUN: begin
        if (halt_req) begin
          next_state = lsti_pkg::LSTI_ST_HALT;
        end else if (!i_adc_enable || manual) begin
          next_state = lsti_pkg::LSTI_ST_IDLE;
        end
      end
      lsti_pkg::LSTI_ST_HALT: begin
        if (!i_adc_enable) begin
          next_state = lsti_pkg::LSTI_ST_IDLE;
        end
      end
      default: begin
        next_state = lsti_pkg::LSTI_ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= lsti_pkg::LSTI_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset || state != lsti_pkg::LSTI_ST_RUN) begin
      ivl_cnt <= '0;
      per_cnt <= 8'h00;
    end else if (ivl_last) begin
      ivl_cnt <= '0;
      per_cnt <= per_last ? 8'h00 : 8'(per_cnt + 8'h01);
    end else begin
      ivl_cnt <= IVL_W'(ivl_cnt + 1'b1);
    end
  end

  // End-of-integration strobe
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      integ_end <= 1'b0;
    end else begin
      integ_end <= period_end && !halt_req;
    end
  end

  assign o_integ_run   = (state == lsti_pkg::LSTI_ST_RUN);
  assign o_integ_end   = integ_end;
  assign o_manual_mode = manual;

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);

  sequence s_outside_conv;
    i_conv_done && outside && mode_level && !irq_clear;
  endsequence

  // Raised, then held unless a clear came in between
  sequence s_irq_held;
    irq ##1 (irq || $past(irq_clear));
  endsequence

  chk_pin_low_drive: assert property (o_irq_n_oe |-> (o_irq_n_out == 1'b0 && irq))
    else $error("interrupt pin not an active-low drive");

  chk_window_compare: assert property ((i_conv_done && mode_level && persist == PERSIST_W'(1) &&
    i_ch0_data == i_low_thresh) |=> irq)
    else $error("value equal to low threshold did not count as outside");

  chk_any_outside: assert property (((persist == PERSIST_W'(1)) ##0 s_outside_conv) |=> s_irq_held)
    else $error("outside result with persist one did not raise interrupt");

  chk_every_cycle: assert property ((i_conv_done && mode_level && persist == '0) |=> irq)
    else $error("persist zero did not interrupt on conversion");

  chk_clear_release: assert property ((irq_clear && !irq_set) |=> (!irq && !o_irq_n_oe))
    else $error("clear did not release interrupt");

  chk_irq_hold: assert property ((irq && !irq_clear) |=> irq)
    else $error("interrupt dropped without clear");

  chk_mode_off: assert property ((!mode_level && !irq) |=> (!irq && !o_irq_n_oe))
    else $error("disabled mode raised interrupt");

  chk_halt_stop: assert property ((state == lsti_pkg::LSTI_ST_RUN && halt_req) |=>
    (!o_integ_run && state == lsti_pkg::LSTI_ST_HALT))
    else $error("integration not halted on interrupt");

  chk_halt_restart: assert property ((state == lsti_pkg::LSTI_ST_HALT && i_adc_enable) |=>
    (state == lsti_pkg::LSTI_ST_HALT))
    else $error("halt left while enable still set");

  chk_manual_idle: assert property (manual |=> !o_integ_run)
    else $error("timer ran in manual mode");

endmodule : lsti_top

// *** tb/lsti_host.sv ***
// Host processor model driving the register, command and enable inputs
module lsti_host (
  // Clock
  input  wire logic       i_mclk,
  // Register port
  output logic            o_reg_wr,
  output logic [4:0]      o_reg_addr,
  output logic [7:0]      o_reg_wdata,
  input  wire logic [7:0] i_reg_rdata,
  // Command and enable
  output logic            o_cmd_wr,
  output logic [1:0]      o_cmd_transaction,
  output logic            o_adc_enable
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus, address parked on the control register
  initial begin
    o_reg_wr = 1'b0;
    o_reg_addr = 5'h02;
    o_reg_wdata = 8'h00;
    o_cmd_wr = 1'b0;
    o_cmd_transaction = 2'h0;
    o_adc_enable = 1'b0;
  end

  // One-cycle write; raw skips the reserved-bit masking
  task automatic reg_write(input logic [4:0] a, input logic [7:0] d, input bit raw);
    @(negedge i_mclk);
    o_reg_wr = 1'b1;
    o_reg_addr = a;
    o_reg_wdata = raw ? d : (d & 8'h5F);
    @(negedge i_mclk);
    o_reg_wr = 1'b0;
  endtask : reg_write

  // Read data is registered one cycle after the address
  task automatic reg_read(input logic [4:0] a, output logic [7:0] d);
    @(negedge i_mclk);
    o_reg_addr = a;
    @(negedge i_mclk);
    d = i_reg_rdata;
  endtask : reg_read

  // Single command byte carrying a transaction code
  task automatic command(input logic [1:0] t);
    @(negedge i_mclk);
    o_cmd_wr = 1'b1;
    o_cmd_transaction = t;
    @(negedge i_mclk);
    o_cmd_wr = 1'b0;
    @(negedge i_mclk);
  endtask : command

  task automatic set_enable(input logic e);
    @(negedge i_mclk);
    o_adc_enable = e;
  endtask : set_enable

  task automatic restart();
    set_enable(1'b0);
    command(2'h3);
    set_enable(1'b1);
  endtask : restart
endmodule : lsti_host

// *** tb/tb.sv ***
// Self-checking testbench of the threshold interrupt block
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk, i_reset, i_conv_done, reg_wr, cmd_wr, adc_en, run, iend, manual, irq, n_out, n_oe;
  logic [15:0] i_ch0_data, lo_th, hi_th;
  logic [7:0]  i_integ_period_count, rdata, wdata, rd;
  logic [4:0]  addr;
  logic [1:0]  trans;
  int          mismatches, num_checks, n;
  wire         irq_pin = n_oe ? n_out : 1'b1;  // Pull-up when released

  lsti_top #(.INTERVAL_CYC(4)) dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_reg_wr(reg_wr), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_cmd_wr(cmd_wr), .i_cmd_transaction(trans),
    .i_adc_enable(adc_en), .i_integ_period_count(i_integ_period_count), .i_low_thresh(lo_th),
    .i_high_thresh(hi_th), .i_conv_done(i_conv_done), .i_ch0_data(i_ch0_data), .o_integ_run(run),
    .o_integ_end(iend), .o_manual_mode(manual), .o_irq_active(irq), .o_irq_n_out(n_out), .o_irq_n_oe(n_oe));
  lsti_host host (.i_mclk(i_mclk), .o_reg_wr(reg_wr), .o_reg_addr(addr), .o_reg_wdata(wdata),
    .i_reg_rdata(rdata), .o_cmd_wr(cmd_wr), .o_cmd_transaction(trans), .o_adc_enable(adc_en));

  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // One completed channel 0 conversion
  task automatic conv(input logic [15:0] d);
    @(negedge i_mclk);
    i_ch0_data = d;
    i_conv_done = 1'b1;
    @(negedge i_mclk);
    i_conv_done = 1'b0;
    @(negedge i_mclk);
  endtask : conv

  // Cycles until the next end-of-integration pulse, bounded
  task automatic wait_end(output int c);
    c = 0;
    do begin
      @(negedge i_mclk);
      c++;
    end while (iend !== 1'b1 && c < 100);
    if (c >= 100) begin
      mismatches++;
      results();
    end
  endtask : wait_end

  initial begin
    i_reset = 1'b1;
    i_conv_done = 1'b0;
    i_ch0_data = 16'h0000;
    lo_th = 16'h0100;
    hi_th = 16'h0800;
    // count 00 selects manual mode; the timer stays idle
    i_integ_period_count = 8'h00;
    repeat (10) @(negedge i_mclk);
    i_reset = 1'b0;
    host.reg_read(5'h02, rd);
    `CHK("ctrl reset", 8'h00, rd)
    `CHK("reset oe", 1'b0, n_oe)
    `CHK("reset run", 1'b0, run)
    host.reg_write(5'h02, 8'hFF, 1'b1);
    host.reg_read(5'h02, rd);
    `CHK("ctrl rsv", 8'h5F, rd)
    host.reg_write(5'h03, 8'h00, 1'b0);
    host.reg_read(5'h02, rd);
    `CHK("other addr wr", 8'h5F, rd)
    host.reg_read(5'h03, rd);
    `CHK("other addr rd", 8'h00, rd)
    `CHK("manual", 1'b1, manual)
    $display("test registers done");
    host.reg_write(5'h02, 8'h13, 1'b0);
    conv(16'h0100);
    conv(16'h0801);
    conv(16'h0800);
    `CHK("irq inside", 1'b0, irq)
    conv(16'h0100);
    conv(16'h0801);
    `CHK("irq two", 1'b0, irq)
    conv(16'h0801);
    `CHK("irq three", 1'b1, irq)
    `CHK("pin low", 1'b0, irq_pin)
    `CHK("irq level", 1'b1, n_oe)
    host.command(2'h2);
    `CHK("irq other", 1'b1, irq)
    host.command(2'h3);
    `CHK("irq clr", 1'b0, irq)
    `CHK("pin high", 1'b1, irq_pin)
    conv(16'h0801);
    `CHK("cnt clr", 1'b0, irq)
    $display("test persistence done");
    host.reg_write(5'h02, 8'h01, 1'b0);
    conv(16'h0801);
    `CHK("off oe", 1'b0, n_oe)
    host.reg_write(5'h02, 8'h10, 1'b0);
    conv(16'h0400);
    `CHK("every", 1'b1, irq)
    host.command(2'h3);
    host.reg_write(5'h02, 8'h11, 1'b0);
    conv(16'h0400);
    `CHK("in win", 1'b0, irq)
    conv(16'h0100);
    `CHK("at low", 1'b1, irq)
    host.command(2'h3);
    // Moved window: raised high threshold, then raised low threshold
    @(negedge i_mclk);
    hi_th = 16'h0900;
    conv(16'h0801);
    `CHK("hi moved", 1'b0, irq)
    @(negedge i_mclk);
    lo_th = 16'h0900;
    conv(16'h0801);
    `CHK("lo moved", 1'b1, irq)
    host.command(2'h3);
    @(negedge i_mclk);
    lo_th = 16'h0100;
    hi_th = 16'h0800;
    $display("test modes done");
    i_integ_period_count = 8'hFE;
    host.set_enable(1'b1);
    wait_end(n);
    wait_end(n);
    `CHK("period", 8, n)
    `CHK("timed", 1'b0, manual)
    host.reg_write(5'h02, 8'h51, 1'b0);
    conv(16'h0801);
    @(negedge i_mclk);
    `CHK("halted", 1'b0, run)
    host.restart();
    repeat (2) @(negedge i_mclk);
    `CHK("resumed", 1'b1, run)
    $display("test halt done");
    results();
  end
endmodule : tb
